// *** common/sfp_pkg.sv ***
package sfp_pkg;
	// ==========================================
	// widths and depths
	localparam int DATA_W = 8;
	localparam int BUF_DEPTH = 2;
	localparam int CNT_W = 2;
	localparam int DIV_W = 3;
	// ==========================================
	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int IFCLK_NOMINAL_MHZ = 60;
	localparam int IFCLK_PERIOD_NS = 400;
	localparam int IFCLK_HALF_CYCLES_INT = IFCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [DIV_W-1:0] IFCLK_HALF_LAST = DIV_W'(IFCLK_HALF_CYCLES_INT - 1);
	// ==========================================
	// reset values and full count
	localparam logic [CNT_W-1:0] CNT_RESET = 2'h0;
	localparam logic [CNT_W-1:0] CNT_FULL = 2'h2;
	localparam logic [DIV_W-1:0] DIV_RESET = 3'h0;
	localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
	localparam logic [2:0] CTL_RESET = 3'h7;
	// control sample field positions
	localparam int CTL_RD = 0;
	localparam int CTL_WR = 1;
	localparam int CTL_OE = 2;
	// ==========================================
	// port modes
	typedef enum logic {
		SFP_MODE_OFF,
		SFP_MODE_SYNC
	} sfp_mode_t;
endpackage : sfp_pkg

// *** rtl/sfp_host_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfp_host_port (
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	// mode control
	input wire logic FIFO_CFG_CH1_I,
	input wire logic MODE_CMD_I,
	output logic SYNC_ACTIVE_O,
	output logic CH2_AVAILABLE_O,
	// receive path from usb buffers
	input wire logic [sfp_pkg::DATA_W-1:0] RX_DATA_I,
	input wire logic RX_VALID_I,
	output logic RX_READY_O,
	// transmit path to usb buffers
	output logic [sfp_pkg::DATA_W-1:0] TX_DATA_O,
	output logic TX_VALID_O,
	input wire logic TX_READY_I,
	// fifo pins
	output logic INTERFACE_CLOCK_O,
	output logic RX_DATA_AVAILABLE_N_O,
	output logic TX_SPACE_AVAILABLE_N_O,
	input wire logic READ_N_I,
	input wire logic WRITE_N_I,
	input wire logic OUTPUT_ENABLE_N_I,
	input wire logic [sfp_pkg::DATA_W-1:0] FIFO_DATA_BUS_I,
	output logic [sfp_pkg::DATA_W-1:0] FIFO_DATA_BUS_O,
	output logic FIFO_DATA_BUS_OE
);
	// ==========================================
	// state
	typedef struct packed {
		sfp_pkg::sfp_mode_t mode;
		logic [sfp_pkg::DIV_W-1:0] div;
		logic ifclk;
		logic [2:0] ctl_s1;
		logic [2:0] ctl_s2;
		logic [sfp_pkg::DATA_W-1:0] bus_s1;
		logic [sfp_pkg::DATA_W-1:0] bus_s2;
		logic [sfp_pkg::BUF_DEPTH-1:0][sfp_pkg::DATA_W-1:0] rx_mem;
		logic rx_wp;
		logic rx_rp;
		logic [sfp_pkg::CNT_W-1:0] rx_cnt;
		logic [sfp_pkg::BUF_DEPTH-1:0][sfp_pkg::DATA_W-1:0] tx_mem;
		logic tx_wp;
		logic tx_rp;
		logic [sfp_pkg::CNT_W-1:0] tx_cnt;
		logic rx_avail_n;
		logic tx_space_n;
		logic [sfp_pkg::DATA_W-1:0] bus_out;
		logic bus_oe;
		logic rx_ready;
		logic tx_valid;
		logic [sfp_pkg::DATA_W-1:0] tx_data;
		logic active;
	} sfp_state_t;

	sfp_state_t st_q;
	sfp_state_t st_d;
	logic rise;
	logic active;
	logic rx_push;
	logic rx_pop;
	logic tx_push;
	logic tx_pop;

	// ==========================================
	// next state
	always_comb begin
		st_d = st_q;
		// pin synchronisers, second stage feeds logic
		st_d.ctl_s1 = {OUTPUT_ENABLE_N_I, WRITE_N_I, READ_N_I};
		st_d.ctl_s2 = st_q.ctl_s1;
		st_d.bus_s1 = FIFO_DATA_BUS_I;
		st_d.bus_s2 = st_q.bus_s1;
		// interface clock divider
		rise = 1'b0;
		if (st_q.div == sfp_pkg::IFCLK_HALF_LAST) begin
			st_d.div = sfp_pkg::DIV_RESET;
			st_d.ifclk = ~st_q.ifclk;
			rise = ~st_q.ifclk;
		end else begin
			st_d.div = st_q.div + 3'h1;
		end
		// mode selection, channel one only
		unique case (st_q.mode)
			sfp_pkg::SFP_MODE_OFF: begin
				if (FIFO_CFG_CH1_I && MODE_CMD_I) begin
					st_d.mode = sfp_pkg::SFP_MODE_SYNC;
				end
			end
			sfp_pkg::SFP_MODE_SYNC: begin
				if (!FIFO_CFG_CH1_I) begin
					st_d.mode = sfp_pkg::SFP_MODE_OFF;
				end
			end
		endcase
		active = (st_q.mode == sfp_pkg::SFP_MODE_SYNC);
		// fifo pin transfers on interface clock rising edge, usb side transfers every clock
		rx_pop = active && rise && !st_q.rx_avail_n && !st_q.ctl_s2[sfp_pkg::CTL_RD];
		tx_push = active && rise && !st_q.tx_space_n && !st_q.ctl_s2[sfp_pkg::CTL_WR];
		rx_push = RX_VALID_I && st_q.rx_ready;
		tx_pop = st_q.tx_valid && TX_READY_I;
		// receive buffer
		if (rx_push) begin
			st_d.rx_mem[st_q.rx_wp] = RX_DATA_I;
			st_d.rx_wp = ~st_q.rx_wp;
		end
		if (rx_pop) begin
			st_d.rx_rp = ~st_q.rx_rp;
		end
		st_d.rx_cnt = st_q.rx_cnt + {1'b0, rx_push} - {1'b0, rx_pop};
		// transmit buffer
		if (tx_push) begin
			st_d.tx_mem[st_q.tx_wp] = st_q.bus_s2;
			st_d.tx_wp = ~st_q.tx_wp;
		end
		if (tx_pop) begin
			st_d.tx_rp = ~st_q.tx_rp;
		end
		st_d.tx_cnt = st_q.tx_cnt + {1'b0, tx_push} - {1'b0, tx_pop};
		// registered outputs
		st_d.active = (st_d.mode == sfp_pkg::SFP_MODE_SYNC);
		st_d.rx_avail_n = !(st_d.active && st_d.rx_cnt != sfp_pkg::CNT_RESET);
		st_d.tx_space_n = !(st_d.active && st_d.tx_cnt != sfp_pkg::CNT_FULL);
		st_d.rx_ready = (st_d.rx_cnt != sfp_pkg::CNT_FULL);
		st_d.tx_valid = (st_d.tx_cnt != sfp_pkg::CNT_RESET);
		st_d.tx_data = st_d.tx_mem[st_d.tx_rp];
		st_d.bus_out = st_d.rx_mem[st_d.rx_rp];
		st_d.bus_oe = st_d.active && !st_q.ctl_s2[sfp_pkg::CTL_OE];
	end

	// ==========================================
	// registers
	always_ff @(posedge CLOCK_I) begin
		if (!RST_B_I) begin
			st_q <= '0;
			st_q.mode <= sfp_pkg::SFP_MODE_OFF;
			st_q.div <= sfp_pkg::DIV_RESET;
			st_q.ctl_s1 <= sfp_pkg::CTL_RESET;
			st_q.ctl_s2 <= sfp_pkg::CTL_RESET;
			st_q.rx_cnt <= sfp_pkg::CNT_RESET;
			st_q.tx_cnt <= sfp_pkg::CNT_RESET;
			st_q.rx_avail_n <= 1'b1;
			st_q.tx_space_n <= 1'b1;
			st_q.rx_ready <= 1'b1;
			st_q.bus_out <= sfp_pkg::DATA_RESET;
			st_q.tx_data <= sfp_pkg::DATA_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================
	// outputs
	assign SYNC_ACTIVE_O = st_q.active;
	assign CH2_AVAILABLE_O = ~st_q.active;
	assign RX_READY_O = st_q.rx_ready;
	assign TX_DATA_O = st_q.tx_data;
	assign TX_VALID_O = st_q.tx_valid;
	assign INTERFACE_CLOCK_O = st_q.ifclk;
	assign RX_DATA_AVAILABLE_N_O = st_q.rx_avail_n;
	assign TX_SPACE_AVAILABLE_N_O = st_q.tx_space_n;
	assign FIFO_DATA_BUS_O = st_q.bus_out;
	assign FIFO_DATA_BUS_OE = st_q.bus_oe;
endmodule : sfp_host_port
`default_nettype wire

// *** testbench/sfp_host_port_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====
// pin and mode checks
module sfp_host_port_checker (
	input wire logic CLOCK_I, RST_B_I, FIFO_CFG_CH1_I, MODE_CMD_I, SYNC_ACTIVE_O,
	input wire logic CH2_AVAILABLE_O, RX_READY_O, TX_VALID_O, INTERFACE_CLOCK_O,
	input wire logic RX_DATA_AVAILABLE_N_O, TX_SPACE_AVAILABLE_N_O, READ_N_I,
	input wire logic WRITE_N_I, OUTPUT_ENABLE_N_I, FIFO_DATA_BUS_OE
);
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RST_B_I);
	sequence s_high; INTERFACE_CLOCK_O [*4] ##1 !INTERFACE_CLOCK_O; endsequence
	a_mode_enter: assert property (!SYNC_ACTIVE_O && FIFO_CFG_CH1_I && MODE_CMD_I
		|=> SYNC_ACTIVE_O) else $error("mode not entered");
	a_mode_gate: assert property (!FIFO_CFG_CH1_I |=> !SYNC_ACTIVE_O)
		else $error("mode without setting");
	a_ch2_off: assert property (CH2_AVAILABLE_O != SYNC_ACTIVE_O)
		else $error("channel two wrong");
	a_bus_input: assert property (OUTPUT_ENABLE_N_I [*4] |-> !FIFO_DATA_BUS_OE)
		else $error("bus driven");
	a_ifclk_half: assert property ($rose(INTERFACE_CLOCK_O) |-> s_high)
		else $error("interface clock period");
	a_rx_pop: assert property ($rose(INTERFACE_CLOCK_O) && $past(RX_DATA_AVAILABLE_N_O) == 1'b0
		&& $past(READ_N_I, 3) == 1'b0 && $past(RX_READY_O) == 1'b0 |-> RX_READY_O)
		else $error("no pop");
	a_tx_push: assert property ($rose(INTERFACE_CLOCK_O) && $past(TX_SPACE_AVAILABLE_N_O) == 1'b0
		&& $past(WRITE_N_I, 3) == 1'b0 |-> TX_VALID_O) else $error("no push");
	a_tx_space: assert property (SYNC_ACTIVE_O && !TX_VALID_O |-> !TX_SPACE_AVAILABLE_N_O)
		else $error("space flag");
endmodule : sfp_host_port_checker
bind sfp_host_port sfp_host_port_checker u_sfp_host_port_checker (.*);
`default_nettype wire

// *** testbench/sfp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====
// host logic on the fifo pins
module sfp_host_model (
	input wire logic ifclk_i, rx_avail_n_i, tx_space_n_i, do_rd_i, do_wr_i,
	input wire logic [7:0] bus_i,
	output logic rd_n_o, wr_n_o, oe_n_o,
	output logic [7:0] dat_o
);
	logic [7:0] got [$];
	logic [7:0] wn = 8'hA0;
	initial {rd_n_o, wr_n_o, oe_n_o, dat_o} = 11'h75A;
	// pins change after the falling edge only
	always @(negedge ifclk_i) begin
		oe_n_o <= !do_rd_i;
		rd_n_o <= !(do_rd_i && !oe_n_o && !rx_avail_n_i);
		if (do_rd_i && !oe_n_o && !rx_avail_n_i) got.push_back(bus_i);
		// write only once the device has let go of the bus
		wr_n_o <= !(do_wr_i && !tx_space_n_i && oe_n_o);
		if (do_wr_i && !tx_space_n_i && oe_n_o) begin
			dat_o <= wn;
			wn = wn + 8'h01;
		end else dat_o <= ~dat_o;
	end
endmodule : sfp_host_model
`default_nettype wire

// *** testbench/test_sfp_host_port.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====
// bench top
module test_sfp_host_port;
	logic clk = 1'b0, rst_b = 1'b0, cfg = 1'b0, cmd = 1'b0, rxv = 1'b0, txr = 1'b0;
	logic do_rd = 1'b0, do_wr = 1'b0, act, ch2, rdy, txv, ifclk, rxa, txs, rdn, wrn, oen, boe;
	logic [7:0] rxd = 8'h00, bo, md, tq, bus;
	int err_count = 0, cmp_count = 0;
	logic [3:0] rows [4] = '{4'h5, 4'h9, 4'hE, 4'h1};
	assign bus = boe ? bo : md;
	always #25 clk = ~clk;
	sfp_host_port u_sfp_host_port (.CLOCK_I(clk), .RST_B_I(rst_b), .FIFO_CFG_CH1_I(cfg),
		.MODE_CMD_I(cmd), .SYNC_ACTIVE_O(act), .CH2_AVAILABLE_O(ch2), .RX_DATA_I(rxd),
		.RX_VALID_I(rxv), .RX_READY_O(rdy), .TX_DATA_O(tq), .TX_VALID_O(txv), .TX_READY_I(txr),
		.INTERFACE_CLOCK_O(ifclk), .RX_DATA_AVAILABLE_N_O(rxa), .TX_SPACE_AVAILABLE_N_O(txs),
		.READ_N_I(rdn), .WRITE_N_I(wrn), .OUTPUT_ENABLE_N_I(oen), .FIFO_DATA_BUS_I(bus),
		.FIFO_DATA_BUS_O(bo), .FIFO_DATA_BUS_OE(boe));
	sfp_host_model u_sfp_host_model (.ifclk_i(ifclk), .rx_avail_n_i(rxa), .tx_space_n_i(txs),
		.do_rd_i(do_rd), .do_wr_i(do_wr), .bus_i(bus), .rd_n_o(rdn), .wr_n_o(wrn),
		.oe_n_o(oen), .dat_o(md));
	task chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task push(input logic [7:0] d);
		rxd = d;
		rxv = 1'b1;
		repeat (200) if (rdy !== 1'b1) tick(1);
		tick(1);
	endtask : push
	task results;
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	initial begin
		#100000;
		err_count++;
		results;
	end
	initial begin
		tick(8);
		chk({act, ch2, rdy, txv, ifclk, rxa, txs, boe}, 8'h66);
		chk(tq | bo, 8'h00);
		rst_b = 1'b1;
		foreach (rows[i]) begin
			{cfg, cmd} = rows[i][3:2];
			tick(1);
			cmd = 1'b0;
			tick(1);
			chk(8'({act, ch2}), 8'(rows[i][1:0]));
		end
		{cfg, cmd} = 2'h3;
		tick(1);
		cmd = 1'b0;
		push(8'h11);
		push(8'h22);
		chk({rdy, rxa}, 8'h00);
		do_rd = 1'b1;
		push(8'h33);
		rxv = 1'b0;
		tick(80);
		chk(8'(u_sfp_host_model.got.size()), 8'h03);
		for (int i = 0; i < 3; i++) chk(u_sfp_host_model.got[i], 8'(8'h11 * (i + 1)));
		chk({rxa, boe}, 8'h03);
		do_rd = 1'b0;
		do_wr = 1'b1;
		tick(60);
		chk({txs, txv}, 8'h03);
		do_wr = 1'b0;
		tick(16);
		txr = 1'b1;
		for (int i = 0; i < 2; i++) begin
			chk(tq, 8'hA0 + 8'(i));
			tick(1);
		end
		chk({txv, txs}, 8'h00);
		results;
	end
endmodule : test_sfp_host_port
`default_nettype wire
